/* rtl/lfb_defs.svh */
// constants for the link fault and bring-up block
// assumes inclusion by the design file and the test bench only
`ifndef LFB_DEFS_SVH
`define LFB_DEFS_SVH
`define LFB_FAULT_CHAR    8'h9c
`define LFB_IDLE_CHAR     8'h07
`define LFB_SEQ_LOCAL     8'h01
`define LFB_SEQ_REMOTE    8'h02
`define LFB_ZERO_BYTE     8'h00
`define LFB_CTRL_ALL      8'hff
`define LFB_CTRL_LANE0    8'h01
`define LFB_CLK_MHZ       25
`define LFB_TRAIN_MS      500
`define LFB_TXDIS_US      2
`define LFB_BAD_HDR_MAX   6'h10
`define LFB_HIGH_ERR_HDR  6'h20
`define LFB_GOOD_HDR_LOCK 6'h3f
`define LFB_ADDR_CTRL     4'h0
`define LFB_ADDR_STAT     4'h1
`define LFB_ADDR_LATCH    4'h2
`define LFB_ADDR_STATE    4'h3
`define LFB_BIT_NO_RF     0
`define LFB_BIT_CLR_LF    1
`define LFB_BIT_CLR_LS    2
`define LFB_BIT_AN_EN     3
`define LFB_BIT_AN_RST    4
`define LFB_BIT_TR_DONE   5
`define LFB_BIT_MGMT      6
`endif

/* rtl/lfb_pkg.sv */
// types for the link fault and bring-up block
// assumes lfb_defs.svh sits on the include path
package lfb_pkg;
  typedef enum logic [5:0] {
    LFB_IDLE_ST  = 6'h01,
    LFB_TXDIS_ST = 6'h02,
    LFB_NEG_ST   = 6'h04,
    LFB_GOOD_ST  = 6'h08,
    LFB_TRAIN_ST = 6'h10,
    LFB_LINK_ST  = 6'h20
  } lfb_an_state_type;
endpackage

/* rtl/lfb_link_fault.sv */
// link fault signalling, status latching and bring-up sequencing
// assumes a 25 MHz core clock, 64-bit xgmii lanes, synchronous inputs
//
// Functional notes
// - fault sets open with 0x9c in lane 0
// - fault and link status immediate and latched
// - latched bits cleared by bit, read, reset
// - not operational receive emits local fault
// - local fault causes: lock, reset, error rate, buffer
// - remote fault only answers local fault
// - received remote fault sends idles only
// - received local fault sends remote fault
// - option disables remote fault transmission
// - link status one after sync and idles; code needs block lock and no local fault, idles not checked
// - fault gone, resume normal transmission
// - bring-up starts with transmitter disabled
// - negotiation runs low rate, checks frames
// - good check then training within 500 ms
// - training complete sets link good, normal mode
// - every restart reruns whole sequence
// - no management: training restarts automatically
// - signal absent holds sync in loss state
// - too many bad headers loses block lock
`timescale 1ns/1ps
`include "lfb_defs.svh"

module lfb_link_fault
  import lfb_pkg::*;
#(
  parameter int TRAIN_CYC = `LFB_TRAIN_MS * `LFB_CLK_MHZ * 1000
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        pcs_reset,
  input  wire logic [63:0] mac_txd,
  input  wire logic [7:0]  mac_txc,
  output logic      [63:0] xgmii_txd,
  output logic      [7:0]  xgmii_txc,
  input  wire logic [63:0] pcs_rxd,
  input  wire logic [7:0]  pcs_rxc,
  output logic      [63:0] mac_rxd,
  output logic      [7:0]  mac_rxc,
  input  wire logic        xcvr_locked,
  input  wire logic        xcvr_in_reset,
  input  wire logic        signal_present,
  input  wire logic        hdr_valid,
  input  wire logic        hdr_good,
  input  wire logic        buf_overflow,
  input  wire logic        buf_underflow,
  input  wire logic        neg_frame_ok,
  input  wire logic        neg_exchange_done,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             tx_disable,
  output logic             low_rate_mode,
  output logic             train_mode,
  output logic             link_good,
  output logic             train_timeout
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [63:0] fault_seq(input logic [7:0] kind);
    fault_seq = {kind, `LFB_ZERO_BYTE, `LFB_ZERO_BYTE, `LFB_ZERO_BYTE,
                 `LFB_ZERO_BYTE, `LFB_ZERO_BYTE, `LFB_ZERO_BYTE, `LFB_FAULT_CHAR};
  endfunction

  function automatic logic is_fault(input logic [63:0] d, input logic [7:0] c,
                                    input logic [7:0] kind);
    is_fault = c[0] && (d[7:0] == `LFB_FAULT_CHAR) && (d[63:56] == kind);
  endfunction

  localparam logic [63:0] IDLE_WORD = {8{`LFB_IDLE_CHAR}};
  localparam int TXDIS_CYC = `LFB_TXDIS_US * `LFB_CLK_MHZ;
  localparam logic [63:0] LF_WORD = fault_seq(`LFB_SEQ_LOCAL);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]       ctrl_r;
  logic             lock_r, lock_nxt;
  logic [5:0]       good_cnt_r, bad_cnt_r;
  logic             high_err_r;
  logic             lf_latch_r, ls_latch_r;
  logic             rx_lf_seen_r, rx_rf_seen_r;
  logic [31:0]      timer_r;
  lfb_an_state_type an_r, an_nxt;

  // ----------------------------------------------------------------
  // block lock and error rate
  // ----------------------------------------------------------------
  wire bad_hdr   = hdr_valid && !hdr_good;
  wire good_hdr  = hdr_valid && hdr_good;
  wire lose_lock = lock_r && bad_cnt_r >= `LFB_BAD_HDR_MAX;
  wire get_lock  = good_cnt_r == `LFB_GOOD_HDR_LOCK;

  always_comb begin
    lock_nxt = lock_r;
    if (!signal_present || pcs_reset) begin
      lock_nxt = 1'b0;
    end else if (lose_lock) begin
      lock_nxt = 1'b0;
    end else if (get_lock) begin
      lock_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lock_r     <= 1'b0;
      good_cnt_r <= '0;
      bad_cnt_r  <= '0;
      high_err_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
      if (!signal_present || bad_hdr || lock_r) begin
        good_cnt_r <= '0;
      end else if (good_hdr) begin
        good_cnt_r <= good_cnt_r + 6'h01;
      end
      if (!signal_present || pcs_reset || get_lock && !lock_r) begin
        bad_cnt_r <= '0;
      end else if (bad_hdr && bad_cnt_r != `LFB_HIGH_ERR_HDR) begin
        bad_cnt_r <= bad_cnt_r + 6'h01;
      end else if (good_hdr && lock_r && bad_cnt_r != '0) begin
        bad_cnt_r <= bad_cnt_r - 6'h01;
      end
      high_err_r <= bad_cnt_r >= `LFB_HIGH_ERR_HDR;
    end
  end

  // ----------------------------------------------------------------
  // receive fault and link status
  // ----------------------------------------------------------------
  logic buf_err_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      buf_err_r <= 1'b1;
    end else if (buf_overflow || buf_underflow || pcs_reset) begin
      buf_err_r <= 1'b1;
    end else if (lock_r) begin
      buf_err_r <= 1'b0;
    end
  end

  wire rx_local_fault = !xcvr_locked || xcvr_in_reset || !lock_r
                        || high_err_r || buf_err_r;
  wire link_up_now    = !rx_local_fault;

  wire rd_latch  = reg_rd && reg_addr == `LFB_ADDR_LATCH;
  wire clr_lf    = ctrl_r[`LFB_BIT_CLR_LF] || rd_latch || pcs_reset;
  wire clr_ls    = ctrl_r[`LFB_BIT_CLR_LS] || rd_latch || pcs_reset;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lf_latch_r <= 1'b1;
      ls_latch_r <= 1'b0;
    end else begin
      lf_latch_r <= rx_local_fault || (lf_latch_r && !clr_lf);
      ls_latch_r <= link_up_now && (ls_latch_r || clr_ls);
    end
  end

  // receive path toward the mac
  wire [63:0] rx_d_nxt = rx_local_fault ? fault_seq(`LFB_SEQ_LOCAL) : pcs_rxd;
  wire [7:0]  rx_c_nxt = rx_local_fault ? `LFB_CTRL_LANE0 : pcs_rxc;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mac_rxd      <= LF_WORD;
      mac_rxc      <= `LFB_CTRL_LANE0;
      rx_lf_seen_r <= 1'b0;
      rx_rf_seen_r <= 1'b0;
    end else begin
      mac_rxd      <= rx_d_nxt;
      mac_rxc      <= rx_c_nxt;
      rx_lf_seen_r <= is_fault(rx_d_nxt, rx_c_nxt, `LFB_SEQ_LOCAL);
      rx_rf_seen_r <= is_fault(rx_d_nxt, rx_c_nxt, `LFB_SEQ_REMOTE);
    end
  end

  // ----------------------------------------------------------------
  // reconciliation transmit
  // ----------------------------------------------------------------
  wire send_rf = rx_lf_seen_r && !ctrl_r[`LFB_BIT_NO_RF];
  wire send_id = rx_rf_seen_r || (rx_lf_seen_r && ctrl_r[`LFB_BIT_NO_RF]);
  wire [63:0] tx_d_nxt = send_rf ? fault_seq(`LFB_SEQ_REMOTE)
                       : send_id ? IDLE_WORD : mac_txd;
  wire [7:0]  tx_c_nxt = send_rf ? `LFB_CTRL_LANE0
                       : send_id ? `LFB_CTRL_ALL : mac_txc;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      xgmii_txd <= IDLE_WORD;
      xgmii_txc <= `LFB_CTRL_ALL;
    end else begin
      xgmii_txd <= tx_d_nxt;
      xgmii_txc <= tx_c_nxt;
    end
  end

  // ----------------------------------------------------------------
  // bring-up sequencer
  // ----------------------------------------------------------------
  wire an_en    = ctrl_r[`LFB_BIT_AN_EN];
  wire an_rst   = ctrl_r[`LFB_BIT_AN_RST] || pcs_reset;
  wire tr_done  = ctrl_r[`LFB_BIT_TR_DONE];
  wire auto_tr  = !ctrl_r[`LFB_BIT_MGMT];
  wire t_txdis  = timer_r >= 32'(TXDIS_CYC);
  wire t_train  = timer_r >= 32'(TRAIN_CYC);

  always_comb begin
    an_nxt = an_r;
    unique case (an_r)
      LFB_IDLE_ST:  if (an_en) an_nxt = LFB_TXDIS_ST;
      LFB_TXDIS_ST: if (t_txdis) an_nxt = LFB_NEG_ST;
      LFB_NEG_ST:   if (neg_exchange_done && neg_frame_ok) an_nxt = LFB_GOOD_ST;
      LFB_GOOD_ST:  if (auto_tr || tr_done) an_nxt = LFB_TRAIN_ST;
      LFB_TRAIN_ST: if (tr_done) an_nxt = LFB_LINK_ST;
                    else if (t_train) an_nxt = LFB_TXDIS_ST;
      LFB_LINK_ST:  an_nxt = LFB_LINK_ST;
    endcase
    if (an_rst) an_nxt = an_en ? LFB_TXDIS_ST : LFB_IDLE_ST;
    else if (!an_en) an_nxt = LFB_IDLE_ST;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      an_r          <= LFB_IDLE_ST;
      timer_r       <= '0;
      tx_disable    <= 1'b0;
      low_rate_mode <= 1'b0;
      train_mode    <= 1'b0;
      link_good     <= 1'b0;
      train_timeout <= 1'b0;
    end else begin
      an_r          <= an_nxt;
      if (an_nxt == LFB_TXDIS_ST && an_r != LFB_TXDIS_ST) timer_r <= '0;
      else if (an_r == LFB_TXDIS_ST && an_nxt == LFB_NEG_ST) timer_r <= '0;
      else if (!t_train) timer_r <= timer_r + 32'h1;
      tx_disable    <= an_nxt == LFB_TXDIS_ST;
      low_rate_mode <= an_nxt == LFB_NEG_ST;
      train_mode    <= an_nxt == LFB_GOOD_ST || an_nxt == LFB_TRAIN_ST;
      link_good     <= an_nxt == LFB_LINK_ST;
      train_timeout <= an_r == LFB_TRAIN_ST && !tr_done && t_train;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  wire [7:0] rd_mux =
      reg_addr == `LFB_ADDR_CTRL  ? ctrl_r :
      reg_addr == `LFB_ADDR_STAT  ? {3'h0, high_err_r, lock_r, link_up_now, rx_local_fault, 1'b0} :
      reg_addr == `LFB_ADDR_LATCH ? {6'h00, ls_latch_r, lf_latch_r} :
      reg_addr == `LFB_ADDR_STATE ? {2'h0, an_r} : 8'h00;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_r    <= 8'h00;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `LFB_ADDR_CTRL) ctrl_r <= reg_wdata;
      else begin
        ctrl_r[`LFB_BIT_CLR_LF] <= 1'b0;
        ctrl_r[`LFB_BIT_CLR_LS] <= 1'b0;
        ctrl_r[`LFB_BIT_AN_RST] <= 1'b0;
      end
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence lf_in_s;
    rx_lf_seen_r && !ctrl_r[`LFB_BIT_NO_RF];
  endsequence

  lf_holds_latch_a: assert property (@(posedge clock) disable iff (!nrst)
    rx_local_fault |=> lf_latch_r)
    else $error("latched local fault not set");
  rf_answer_a: assert property (@(posedge clock) disable iff (!nrst)
    lf_in_s |=> xgmii_txd[7:0] == `LFB_FAULT_CHAR && xgmii_txd[63:56] == `LFB_SEQ_REMOTE)
    else $error("remote fault not sent");
  rf_idle_a: assert property (@(posedge clock) disable iff (!nrst)
    rx_rf_seen_r && !rx_lf_seen_r |=> xgmii_txd == IDLE_WORD)
    else $error("idles not sent");
  no_rf_opt_a: assert property (@(posedge clock) disable iff (!nrst)
    ctrl_r[`LFB_BIT_NO_RF] |=> xgmii_txd[63:56] != `LFB_SEQ_REMOTE || xgmii_txd[7:0] != `LFB_FAULT_CHAR
      || $past(mac_txd[63:56]) == `LFB_SEQ_REMOTE)
    else $error("remote fault sent while disabled");
  rx_lf_out_a: assert property (@(posedge clock) disable iff (!nrst)
    rx_local_fault |=> mac_rxc[0] && mac_rxd[7:0] == `LFB_FAULT_CHAR && mac_rxd[63:56] == `LFB_SEQ_LOCAL)
    else $error("local fault not sent to mac");
  sig_loss_a: assert property (@(posedge clock) disable iff (!nrst)
    !signal_present |=> !lock_r)
    else $error("lock held without signal");
  link_stat_a: assert property (@(posedge clock) disable iff (!nrst)
    !lock_r |-> !link_up_now)
    else $error("link up without lock");
  txdis_first_a: assert property (@(posedge clock) disable iff (!nrst)
    an_r == LFB_IDLE_ST && an_nxt == LFB_TXDIS_ST |=> tx_disable)
    else $error("transmitter not disabled");
  good_link_a: assert property (@(posedge clock) disable iff (!nrst)
    an_r == LFB_TRAIN_ST && tr_done && !an_rst && an_en |=> link_good)
    else $error("link good missing");
  restart_a: assert property (@(posedge clock) disable iff (!nrst)
    an_rst && an_en |=> an_r == LFB_TXDIS_ST && !link_good)
    else $error("restart did not rerun");

  // ----------------------------------------------------------------
  // further checks
  // ----------------------------------------------------------------
  sequence neg_start_s;
    an_r == LFB_TXDIS_ST && an_nxt == LFB_NEG_ST;
  endsequence

  sequence neg_pass_s;
    an_r == LFB_NEG_ST && neg_exchange_done && neg_frame_ok && !an_rst && an_en;
  endsequence

  ls_drop_a: assert property (@(posedge clock) disable iff (!nrst)
    !link_up_now |=> !ls_latch_r)
    else $error("latched link not dropped");

  lf_read_clr_a: assert property (@(posedge clock) disable iff (!nrst)
    !rx_local_fault && rd_latch |=> !lf_latch_r)
    else $error("latched fault not cleared");

  buf_fault_a: assert property (@(posedge clock) disable iff (!nrst)
    buf_overflow || buf_underflow |=> rx_local_fault)
    else $error("buffer error not a fault");

  rf_origin_a: assert property (@(posedge clock) disable iff (!nrst)
    xgmii_txc[0] && xgmii_txd == LF_WORD + 64'h0100_0000_0000_0000
      |-> $past(rx_lf_seen_r) || $past(mac_txd) == xgmii_txd)
    else $error("remote fault not from local fault");

  tx_resume_a: assert property (@(posedge clock) disable iff (!nrst)
    !rx_lf_seen_r && !rx_rf_seen_r |=> xgmii_txd == $past(mac_txd))
    else $error("transmit data not resumed");

  lock_loss_a: assert property (@(posedge clock) disable iff (!nrst)
    lock_r && bad_cnt_r >= `LFB_BAD_HDR_MAX |=> !lock_r)
    else $error("lock kept after bad headers");

  neg_rate_a: assert property (@(posedge clock) disable iff (!nrst)
    neg_start_s |=> low_rate_mode && !tx_disable)
    else $error("low rate mode missing");

  neg_timer_a: assert property (@(posedge clock) disable iff (!nrst)
    neg_start_s |=> timer_r == '0)
    else $error("training timer not restarted");

  train_enter_a: assert property (@(posedge clock) disable iff (!nrst)
    neg_pass_s |=> train_mode)
    else $error("training not entered");

  train_limit_a: assert property (@(posedge clock) disable iff (!nrst)
    an_r == LFB_TRAIN_ST |-> timer_r <= 32'(TRAIN_CYC))
    else $error("training timer overrun");

  auto_train_a: assert property (@(posedge clock) disable iff (!nrst)
    an_r == LFB_GOOD_ST && auto_tr && an_en && !an_rst |=> an_r == LFB_TRAIN_ST)
    else $error("training not restarted");

  link_norm_a: assert property (@(posedge clock) disable iff (!nrst)
    link_good |-> !low_rate_mode && !train_mode && !tx_disable)
    else $error("link good outside normal mode");

  rdata_idle_a: assert property (@(posedge clock) disable iff (!nrst)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside read");

endmodule // lfb_link_fault

/* verif/lfb_partner.sv */
// far-side link partner model driving the receive word and sync headers
// assumes the bench picks the traffic mode and bad-header bursts
`timescale 1ns/1ps

module lfb_partner (
  input  wire logic        clock,
  input  wire logic [1:0]  mode,
  input  wire logic        bad_hdr,
  output logic      [63:0] pcs_rxd,
  output logic      [7:0]  pcs_rxc,
  output logic             hdr_valid,
  output logic             hdr_good
);
  // ----------------------------------------
  // mode 0 idles, 1 data, 2 remote, 3 local
  // ----------------------------------------
  initial begin
    pcs_rxd   = {8{8'h07}};
    pcs_rxc   = 8'hff;
    hdr_valid = 1'b0;
    hdr_good  = 1'b0;
  end

  always @(posedge clock) begin
    hdr_valid <= 1'b1;
    hdr_good  <= !bad_hdr;
    case (mode)
      2'h0: begin
        pcs_rxd <= {8{8'h07}};
        pcs_rxc <= 8'hff;
      end
      2'h1: begin
        pcs_rxd <= {$urandom, $urandom};
        pcs_rxc <= 8'h00;
      end
      default: begin
        pcs_rxd <= {(mode == 2'h2) ? 8'h02 : 8'h01, 48'h0, 8'h9c};
        pcs_rxc <= 8'h01;
      end
    endcase
  end
endmodule // lfb_partner

/* verif/lfb_link_fault_test.sv */
// self-checking bench for the link fault and bring-up block
// assumes lfb_partner on the receive side, short training timer
`timescale 1ns/1ps
`include "lfb_defs.svh"

module lfb_link_fault_test;
  import lfb_pkg::*;
  logic        clock, nrst, pcs_reset, xcvr_locked, xcvr_in_reset, signal_present;
  logic        hdr_valid, hdr_good, buf_overflow, buf_underflow, neg_frame_ok;
  logic        neg_exchange_done, reg_wr, reg_rd, tx_disable, low_rate_mode;
  logic        train_mode, link_good, train_timeout, bad_hdr;
  logic [63:0] mac_txd, xgmii_txd, pcs_rxd, mac_rxd;
  logic [7:0]  mac_txc, xgmii_txc, pcs_rxc, mac_rxc, reg_wdata, reg_rdata, rd_val;
  logic [3:0]  reg_addr;
  logic [1:0]  mode;
  int          error_cnt, total_checks, cyc;

  lfb_link_fault #(.TRAIN_CYC(200)) i_lfb_link_fault (.clock, .nrst, .pcs_reset, .mac_txd, .mac_txc,
    .xgmii_txd, .xgmii_txc, .pcs_rxd, .pcs_rxc, .mac_rxd, .mac_rxc, .xcvr_locked, .xcvr_in_reset,
    .signal_present, .hdr_valid, .hdr_good, .buf_overflow, .buf_underflow, .neg_frame_ok,
    .neg_exchange_done, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_disable,
    .low_rate_mode, .train_mode, .link_good, .train_timeout);
  lfb_partner i_lfb_partner (.clock, .mode, .bad_hdr, .pcs_rxd, .pcs_rxc, .hdr_valid, .hdr_good);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [63:0] fault_word(logic [7:0] k);
    return {k, 48'h0, `LFB_FAULT_CHAR};
  endfunction

  function automatic logic ob(int b);
    logic [4:0] v;
    v = {train_timeout, link_good, train_mode, low_rate_mode, tx_disable};
    return v[b];
  endfunction

  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  task automatic tx_chk(int n, logic pass, logic [63:0] w);
    logic [63:0] t, r;
    repeat (n) begin
      @(posedge clock);
      mac_txd <= {$urandom, $urandom};
      #1 t = mac_txd;
      r = pcs_rxd;
      @(posedge clock);
      #1 chk("xgmii_txd", xgmii_txd, pass ? t : w);
      if (pass) chk("mac_rxd", mac_rxd, r);
    end
  endtask

  task automatic wait_bit(int b, int lim, string nm);
    int i;
    i = 0;
    while (ob(b) !== 1'b1 && i < lim) begin
      @(posedge clock);
      #1 i++;
    end
    chk(nm, ob(b), 1'b1);
  endtask

  // ----------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    {nrst, pcs_reset, xcvr_locked, xcvr_in_reset, buf_overflow, buf_underflow} = '0;
    {neg_frame_ok, neg_exchange_done, reg_wr, reg_rd, bad_hdr} = '0;
    {signal_present, mode, mac_txc, reg_addr, reg_wdata, mac_txd} = {1'b1, 2'h0, 8'h00, 4'h0, 8'h00, 64'h0};
    void'($urandom(68));
    tick(5);
    chk("rst xgmii_txd", {xgmii_txc, xgmii_txd}, {8'hff, {8{`LFB_IDLE_CHAR}}});
    chk("rst mac_rxd", {mac_rxc, mac_rxd}, {8'h01, fault_word(`LFB_SEQ_LOCAL)});
    chk("rst modes", {link_good, train_mode, low_rate_mode, tx_disable}, 4'h0);
    nrst <= 1'b1;
    tick(3);
    chk("lf mac_rxd", mac_rxd, fault_word(`LFB_SEQ_LOCAL));
    tx_chk(3, 1'b0, fault_word(`LFB_SEQ_REMOTE));
    chk("rf lane0 ctrl", xgmii_txc[0], 1'b1);
    rd(`LFB_ADDR_STAT);
    chk("stat lf", rd_val[1], 1'b1);
    rd(4'h9);
    chk("unmapped", rd_val, 8'h00);
    wr(`LFB_ADDR_CTRL, 8'h01);
    tick(3);
    tx_chk(3, 1'b0, {8{`LFB_IDLE_CHAR}});
    wr(`LFB_ADDR_CTRL, 8'h00);
    $display("test fault done");
    xcvr_locked <= 1'b1;
    tick(80);
    rd(`LFB_ADDR_STAT);
    chk("stat up", rd_val & 8'h1e, 8'h0c);
    mode <= 2'h1;
    tick(2);
    tx_chk(8, 1'b1, 64'h0);
    rd(`LFB_ADDR_LATCH);
    chk("latch seen", rd_val & 8'h03, 8'h01);
    rd(`LFB_ADDR_LATCH);
    chk("latch read clr", rd_val & 8'h03, 8'h02);
    $display("test link up done");
    mode <= 2'h2;
    tick(3);
    tx_chk(4, 1'b0, {8{`LFB_IDLE_CHAR}});
    mode <= 2'h3;
    tick(3);
    tx_chk(4, 1'b0, fault_word(`LFB_SEQ_REMOTE));
    mode <= 2'h0;
    tick(3);
    tx_chk(4, 1'b1, 64'h0);
    $display("test received fault done");
    bad_hdr <= 1'b1;
    tick(20);
    bad_hdr <= 1'b0;
    rd(`LFB_ADDR_STAT);
    chk("bad hdr lock", rd_val & 8'h1a, 8'h02);
    chk("bad hdr lf", mac_rxd, fault_word(`LFB_SEQ_LOCAL));
    tick(80);
    wr(`LFB_ADDR_CTRL, 8'h06);
    rd(`LFB_ADDR_LATCH);
    chk("latch bit clr", rd_val & 8'h03, 8'h02);
    signal_present <= 1'b0;
    tick(3);
    rd(`LFB_ADDR_STAT);
    chk("no signal", rd_val & 8'h0a, 8'h02);
    signal_present <= 1'b1;
    tick(80);
    for (int k = 0; k < 2; k++) begin
      rd(`LFB_ADDR_LATCH);
      {buf_underflow, buf_overflow} <= k[0] ? 2'b10 : 2'b01;
      @(posedge clock);
      {buf_underflow, buf_overflow} <= 2'b00;
      tick(3);
      rd(`LFB_ADDR_LATCH);
      chk("buf latch", rd_val[0], 1'b1);
      tick(80);
    end
    $display("test lock done");
    wr(`LFB_ADDR_CTRL, 8'h08);
    wait_bit(0, 10, "tx_disable");
    rd(`LFB_ADDR_STATE);
    chk("state txdis", rd_val, LFB_TXDIS_ST);
    wait_bit(1, 100, "low_rate_mode");
    {neg_frame_ok, neg_exchange_done} <= 2'b11;
    wait_bit(2, 20, "train_mode");
    rd(`LFB_ADDR_STATE);
    chk("state train", rd_val, LFB_TRAIN_ST);
    wait_bit(4, 300, "train_timeout");
    wr(`LFB_ADDR_CTRL, 8'h18);
    wait_bit(0, 10, "restart txdis");
    wait_bit(2, 200, "train again");
    wr(`LFB_ADDR_CTRL, 8'h28);
    wait_bit(3, 10, "link_good");
    chk("normal mode", {low_rate_mode, train_mode}, 2'b00);
    rd(`LFB_ADDR_STATE);
    chk("state link", rd_val, LFB_LINK_ST);
    wr(`LFB_ADDR_CTRL, 8'h58);
    wait_bit(0, 10, "mgmt txdis");
    chk("link dropped", link_good, 1'b0);
    wait_bit(2, 100, "mgmt good check");
    tick(5);
    rd(`LFB_ADDR_STATE);
    chk("state held", rd_val, LFB_GOOD_ST);
    wr(`LFB_ADDR_CTRL, 8'h68);
    wait_bit(3, 10, "mgmt link_good");
    $display("test bring-up done");
    summarize();
  end
endmodule // lfb_link_fault_test
